/* hdl/kp_host_pkg.sv */
/*
 * Constants, codes and types for the keypad companion's serial host
 * command interface. Assumes a 10 MHz core clock.
 */
package kp_host_pkg;

    // ======================================================
    // Bus addressing and commands
    localparam logic [6:0] SLAVE_ADDR          = 7'h51;
    localparam logic [7:0] CMD_FIFO_READ       = 8'h20;
    localparam logic [7:0] CMD_REREAD          = 8'h21;
    localparam logic [7:0] CMD_DEBOUNCE        = 8'h22;
    localparam logic [7:0] CMD_PIN_IRQ         = 8'hd1;
    localparam logic [7:0] CMD_ACTIVE          = 8'he4;
    localparam logic [7:0] OFS_INTERRUPT_CAUSE = 8'hd0;
    localparam logic [7:0] OFS_DEVICE_STATUS   = 8'he0;
    localparam logic [7:0] OFS_FAULT_CAUSE     = 8'hf0;

    // ======================================================
    // Field positions and fixed patterns
    localparam int unsigned CAUSE_KEY     = 0;
    localparam int unsigned CAUSE_AUX0    = 1;
    localparam int unsigned CAUSE_AUX1    = 2;
    localparam int unsigned CAUSE_ERR     = 3;
    localparam int unsigned FAULT_EARLY   = 0;
    localparam int unsigned FAULT_INVALID = 1;
    localparam int unsigned FAULT_KEYS    = 2;
    localparam int unsigned FAULT_WITHDRN = 4;
    localparam int unsigned FAULT_QUEUE   = 6;
    localparam logic [7:0] CAUSE_ZERO_MASK = 8'hf0;
    localparam logic [7:0] FAULT_ZERO_MASK = 8'ha8;
    localparam logic [7:0] STAT_RESET      = 8'h00;
    localparam logic [7:0] STAT_WAKE       = 8'h02;
    localparam logic [7:0] STAT_ACK        = 8'h06;
    localparam logic [7:0] STAT_NOACK      = 8'h15;
    localparam logic [7:0] EMPTY_CODE      = 8'h00;
    localparam logic [3:0] FIFO_DEPTH      = 4'he;

    // ======================================================
    // Timing
    localparam int unsigned CORE_CLK_KHZ = 10000;
    localparam int unsigned STEP_MS      = 4;
    localparam int unsigned DEBOUNCE_MS  = 10;
    localparam int unsigned ACTIVE_MS    = 500;
    localparam int unsigned STEP_CYCLES  = STEP_MS * CORE_CLK_KHZ;
    localparam logic [7:0] DEBOUNCE_RST =
        8'((DEBOUNCE_MS + STEP_MS - 1) / STEP_MS);
    localparam logic [7:0] ACTIVE_RST =
        8'((ACTIVE_MS + STEP_MS - 1) / STEP_MS);

    // ======================================================
    // Types
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {EV_CMD, EV_WDATA, EV_RFIRST, EV_RNEXT} bus_ev_t;
    typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_CMD, PH_WDATA, PH_TX}
        phase_t;

endpackage

/* hdl/kp_host_cmd.sv */
/*
 * Host command interface of a keypad companion: serial bus slave on the
 * host clock line, command decoder, cause/fault/status codes, event
 * queue and halt timer. Assumes the bench resolves the open-drain wires
 * from the enables, and the scanner delivers events on core_clk.
 */
// Overview of operation
// - Device answers only addresses 0xa2 and 0xa3
// - Upper seven bits address, bit zero direction
// - Receiver acknowledges; host ends read with NACK
// - Read: address, command, restart, address, data
// - Write: address, command, data in one transfer
// - Bus activity wakes; first address left unacknowledged
// - After NACK host retries; awake device acknowledges
// - Device holds clock low while busy
// - Key event pulls request low; cause read clears
// - Cause byte: error, pin one, pin zero, key
// - One pin enabled sets both pin bits
// - Enabled pin edge wakes and raises request
// - Fault command returns and clears fault byte
// - Fault byte layout with three zero bits
// - Status byte: reset, wake, success, failure codes
// - Queue holds fourteen events, empty code zero
// - Reread returns events without advancing pointer
// - Debounce default ten ms, four ms steps
// - Active period default 500 ms before halt
`timescale 1ns/1ps
module kp_host_cmd
#(
    parameter int unsigned STEP_CYC = kp_host_pkg::STEP_CYCLES
)
(
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire logic               scl_clk,
    output logic                    scl_o,
    output logic                    scl_oe_n,
    input  wire logic               sda_i,
    output logic                    sda_o,
    output logic                    sda_oe_n,
    input  wire logic               key_valid,
    input  wire kp_host_pkg::byte_t key_code,
    input  wire logic               key_overflow,
    input  wire logic               aux_pin_zero,
    input  wire logic               aux_pin_one,
    output logic                    irq_n,
    output logic                    active_mode,
    output kp_host_pkg::byte_t      debounce_code
);
    import kp_host_pkg::*;

    // ======================================================
    // Link side, clocked by the host clock line
    logic [1:0] lrst_q;
    logic [1:0] awake_l_q;
    logic       lrst_n;
    logic       sda_pos_q;
    byte_t      shift_q;
    logic       host_ack_q;
    logic [3:0] bit_q;
    phase_t     phase_q;
    logic       ack_q;
    logic       rd_dir_q;
    logic       str_tog_q;
    logic       act_tog_q;
    bus_ev_t    ev_kind_q;
    byte_t      ev_byte_q;
    logic       start;
    byte_t      tx_byte_q;
    logic       rel_tog_q;
    logic       awake_q;

    // Reset and wake level brought over into the link domain
    always_ff @(negedge scl_clk)
    begin
        lrst_q    <= {lrst_q[0], rst_n};
        awake_l_q <= {awake_l_q[0], awake_q};
    end
    assign lrst_n = lrst_q[1];

    // Sample data on the rising clock edge
    always_ff @(posedge scl_clk)
    begin
        if (!lrst_n)
        begin
            sda_pos_q  <= 1'b1;
            shift_q    <= 8'h00;
            host_ack_q <= 1'b0;
        end
        else
        begin
            sda_pos_q <= sda_i;
            if (bit_q != 4'd8)
                shift_q <= {shift_q[6:0], sda_i};
            else
                host_ack_q <= ~sda_i;
        end
    end

    // Data falling while the clock was high: a start
    assign start = sda_pos_q & ~sda_i;

    // Byte framing, acknowledge and stretch requests on falling edge
    always_ff @(negedge scl_clk)
    begin
        if (!lrst_n)
        begin
            phase_q   <= PH_IDLE;
            bit_q     <= 4'd0;
            ack_q     <= 1'b0;
            rd_dir_q  <= 1'b0;
            str_tog_q <= 1'b0;
            act_tog_q <= 1'b0;
            ev_kind_q <= EV_CMD;
            ev_byte_q <= 8'h00;
        end
        else if (start)
        begin
            phase_q <= PH_ADDR;
            bit_q   <= 4'd0;
            ack_q   <= 1'b0;
        end
        else if (bit_q == 4'd7)
        begin
            bit_q <= 4'd8;
            unique case (phase_q)
                PH_ADDR:
                begin
                    // Halted device lets the first address go by
                    act_tog_q <= ~act_tog_q;
                    ack_q     <= awake_l_q[1] &&
                                 shift_q[7:1] == SLAVE_ADDR;
                    rd_dir_q  <= shift_q[0];
                end
                PH_CMD, PH_WDATA:
                begin
                    ack_q     <= 1'b1;
                    ev_byte_q <= shift_q;
                end
                default: ack_q <= 1'b0;
            endcase
        end
        else if (bit_q == 4'd8)
        begin
            bit_q <= 4'd0;
            ack_q <= 1'b0;
            unique case (phase_q)
                PH_ADDR:
                    if (!ack_q)
                        phase_q <= PH_IDLE;
                    else if (rd_dir_q)
                    begin
                        phase_q   <= PH_TX;
                        ev_kind_q <= EV_RFIRST;
                        str_tog_q <= ~str_tog_q;
                    end
                    else
                        phase_q <= PH_CMD;
                PH_CMD:
                begin
                    phase_q   <= PH_WDATA;
                    ev_kind_q <= EV_CMD;
                    str_tog_q <= ~str_tog_q;
                end
                PH_WDATA:
                begin
                    ev_kind_q <= EV_WDATA;
                    str_tog_q <= ~str_tog_q;
                end
                PH_TX:
                    if (host_ack_q)
                    begin
                        ev_kind_q <= EV_RNEXT;
                        str_tog_q <= ~str_tog_q;
                    end
                    else
                        phase_q <= PH_IDLE;
                default: ;
            endcase
        end
        else
            bit_q <= bit_q + 4'd1;
    end

    // Open-drain pins; clock held low until the core answers
    assign scl_o    = 1'b0;
    assign scl_oe_n = ~(str_tog_q ^ rel_tog_q);
    assign sda_o    = 1'b0;
    assign sda_oe_n = ~(ack_q | (phase_q == PH_TX && bit_q != 4'd8 &&
                      !tx_byte_q[3'd7 - bit_q[2:0]]));

    // ======================================================
    // Core side
    function automatic logic cmd_known(input byte_t c);
        return c == CMD_FIFO_READ || c == CMD_REREAD ||
               c == CMD_DEBOUNCE  || c == CMD_PIN_IRQ ||
               c == CMD_ACTIVE    || c == OFS_INTERRUPT_CAUSE ||
               c == OFS_DEVICE_STATUS || c == OFS_FAULT_CAUSE;
    endfunction

    function automatic logic [3:0] wrap(input logic [4:0] v);
        return (v >= {1'b0, FIFO_DEPTH}) ? 4'(v - {1'b0, FIFO_DEPTH})
                                         : v[3:0];
    endfunction

    logic [1:0]  ev_sync_q;
    logic        ev_seen_q;
    logic [1:0]  act_sync_q;
    logic        act_seen_q;
    logic [2:0]  aux0_q;
    logic [2:0]  aux1_q;
    logic        bev;
    logic        bev_cmd;
    logic        bev_wr;
    logic        bev_rd;
    logic        act_ev;
    logic        bad_cmd;
    logic        e0;
    logic        e1;
    logic        single;
    logic        do_push;
    logic        pop;
    logic        serve_cause;
    logic        serve_fault;
    byte_t       cause_q;
    byte_t       fault_q;
    byte_t       status_q;
    byte_t       cmd_q;
    byte_t       active_q;
    byte_t       debounce_q;
    byte_t       cause_set;
    byte_t       fault_set;
    logic [1:0]  irq_en_q;
    logic [15:0] pre_q;
    logic [7:0]  left_q;
    byte_t       mem [0:13];
    logic [3:0]  rd_q;
    logic [3:0]  wr_q;
    logic [3:0]  fcnt_q;
    logic [3:0]  peek_q;
    logic        irq_n_q;

    // Crossings: toggles and pins through two flops each
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            ev_sync_q  <= 2'b00;
            ev_seen_q  <= 1'b0;
            rel_tog_q  <= 1'b0;
            act_sync_q <= 2'b00;
            act_seen_q <= 1'b0;
            aux0_q     <= 3'b000;
            aux1_q     <= 3'b000;
        end
        else
        begin
            ev_sync_q  <= {ev_sync_q[0], str_tog_q};
            ev_seen_q  <= ev_sync_q[1];
            // Release one cycle after the answer byte settles
            rel_tog_q  <= ev_seen_q;
            act_sync_q <= {act_sync_q[0], act_tog_q};
            act_seen_q <= act_sync_q[1];
            aux0_q     <= {aux0_q[1:0], aux_pin_zero};
            aux1_q     <= {aux1_q[1:0], aux_pin_one};
        end
    end

    assign bev     = ev_sync_q[1] ^ ev_seen_q;
    assign act_ev  = act_sync_q[1] ^ act_seen_q;
    assign bev_cmd = bev && ev_kind_q == EV_CMD;
    assign bev_wr  = bev && ev_kind_q == EV_WDATA;
    assign bev_rd  = bev && (ev_kind_q == EV_RFIRST ||
                             ev_kind_q == EV_RNEXT);
    assign bad_cmd = bev_cmd && !cmd_known(ev_byte_q);
    assign serve_cause = bev_rd && cmd_q == OFS_INTERRUPT_CAUSE;
    assign serve_fault = bev_rd && cmd_q == OFS_FAULT_CAUSE;
    assign e0      = irq_en_q[0] && (aux0_q[2] ^ aux0_q[1]);
    assign e1      = irq_en_q[1] && (aux1_q[2] ^ aux1_q[1]);
    assign single  = irq_en_q != 2'b11;
    assign do_push = key_valid && fcnt_q != FIFO_DEPTH;
    assign pop     = bev_rd && cmd_q == CMD_FIFO_READ && fcnt_q != 4'd0;

    // Fault sources; withdrawn alert has no source in this block
    always_comb
    begin
        fault_set = 8'h00;
        fault_set[FAULT_QUEUE]   = key_valid && !do_push;
        fault_set[FAULT_KEYS]    = key_overflow;
        fault_set[FAULT_INVALID] = bad_cmd;
    end

    // Cause sources; a lone enabled pin reports on both bits
    always_comb
    begin
        cause_set = 8'h00;
        cause_set[CAUSE_KEY]  = key_valid;
        cause_set[CAUSE_AUX0] = e0 | (single & e1);
        cause_set[CAUSE_AUX1] = e1 | (single & e0);
        cause_set[CAUSE_ERR]  = |fault_set;
    end

    // Sticky codes; a new event wins over the read that clears
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            cause_q <= 8'h00;
            fault_q <= 8'h00;
            irq_n_q <= 1'b1;
        end
        else
        begin
            cause_q <= (serve_cause ? 8'h00 : cause_q) | cause_set;
            fault_q <= (serve_fault ? 8'h00 : fault_q) | fault_set;
            irq_n_q <= cause_q == 8'h00;
        end
    end

    // Command latch, settings and status code
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            cmd_q      <= 8'h00;
            irq_en_q   <= 2'b00;
            debounce_q <= DEBOUNCE_RST;
            active_q   <= ACTIVE_RST;
            status_q   <= STAT_RESET;
        end
        else
        begin
            if (bev_cmd)
            begin
                cmd_q    <= ev_byte_q;
                // Status read leaves the code it is about to report
                if (ev_byte_q != OFS_DEVICE_STATUS)
                    status_q <= bad_cmd ? STAT_NOACK : STAT_ACK;
            end
            else if (bev_wr)
            begin
                if (cmd_q == CMD_PIN_IRQ)
                    irq_en_q <= ev_byte_q[1:0];
                if (cmd_q == CMD_DEBOUNCE)
                    debounce_q <= ev_byte_q;
                if (cmd_q == CMD_ACTIVE)
                    active_q <= ev_byte_q;
                status_q <= STAT_ACK;
            end
            else if ((e0 || e1) && !awake_q)
                status_q <= STAT_WAKE;
        end
    end

    // Halt timer counted in 4 ms steps of the active period
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            awake_q <= 1'b1;
            pre_q   <= 16'h0000;
            left_q  <= ACTIVE_RST;
        end
        else if (act_ev || bev || key_valid || e0 || e1)
        begin
            awake_q <= 1'b1;
            pre_q   <= 16'h0000;
            // A new active period counts from its own write
            left_q  <= (bev_wr && cmd_q == CMD_ACTIVE) ? ev_byte_q
                                                       : active_q;
        end
        else if (awake_q)
        begin
            if (pre_q == 16'(STEP_CYC - 1))
            begin
                pre_q <= 16'h0000;
                if (left_q <= 8'd1)
                    awake_q <= 1'b0;
                else
                    left_q <= left_q - 8'd1;
            end
            else
                pre_q <= pre_q + 16'h0001;
        end
    end

    // Event queue; reread walks a private offset instead
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            rd_q   <= 4'd0;
            wr_q   <= 4'd0;
            fcnt_q <= 4'd0;
            peek_q <= 4'd0;
        end
        else
        begin
            if (do_push)
            begin
                mem[wr_q] <= key_code;
                wr_q      <= wrap({1'b0, wr_q} + 5'd1);
            end
            if (pop)
                rd_q <= wrap({1'b0, rd_q} + 5'd1);
            if (do_push && !pop)
                fcnt_q <= fcnt_q + 4'd1;
            else if (pop && !do_push)
                fcnt_q <= fcnt_q - 4'd1;
            if (bev_cmd)
                peek_q <= 4'd0;
            else if (bev_rd && cmd_q == CMD_REREAD && peek_q < fcnt_q)
                peek_q <= peek_q + 4'd1;
        end
    end

    // Answer byte, loaded while the clock line is held low
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            tx_byte_q <= 8'hff;
        else if (bev_rd)
        begin
            unique case (cmd_q)
                OFS_INTERRUPT_CAUSE: tx_byte_q <= cause_q;
                OFS_DEVICE_STATUS:   tx_byte_q <= status_q;
                OFS_FAULT_CAUSE:     tx_byte_q <= fault_q;
                CMD_FIFO_READ:
                    tx_byte_q <= (fcnt_q != 4'd0) ? mem[rd_q]
                                                  : EMPTY_CODE;
                CMD_REREAD:
                    tx_byte_q <= (peek_q < fcnt_q)
                        ? mem[wrap({1'b0, rd_q} + {1'b0, peek_q})]
                        : EMPTY_CODE;
                default: tx_byte_q <= EMPTY_CODE;
            endcase
        end
    end

    assign irq_n         = irq_n_q;
    assign active_mode   = awake_q;
    assign debounce_code = debounce_q;

    // ======================================================
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    key_irq_a: assert property (key_valid |-> ##2 !irq_n)
        else $error("key event did not raise request");
    cause_clear_a: assert property (
        serve_cause && cause_set == 8'h00 |=> cause_q == 8'h00 ##1 irq_n)
        else $error("cause read did not clear");
    cause_top_a: assert property (
        (cause_q & CAUSE_ZERO_MASK) == 8'h00)
        else $error("cause upper bits set");
    aux_both_a: assert property (
        e0 && irq_en_q == 2'b01 |=> cause_q[2:1] == 2'b11)
        else $error("lone pin did not set both bits");
    aux_one_a: assert property (e1 && !e0 && irq_en_q == 2'b11 &&
        !serve_cause |=> cause_q[2] && cause_q[1] == $past(cause_q[1]))
        else $error("pin bit mixed up");
    aux_wake_a: assert property (
        e0 && !awake_q && !bev |=> awake_q && status_q == STAT_WAKE)
        else $error("pin edge did not wake");
    fault_clear_a: assert property (
        serve_fault && fault_set == 8'h00 |=> fault_q == 8'h00)
        else $error("fault read did not clear");
    fault_zero_a: assert property (
        (fault_q & FAULT_ZERO_MASK) == 8'h00)
        else $error("fault zero bits set");
    bad_cmd_a: assert property (bad_cmd |=>
        fault_q[FAULT_INVALID] && cause_q[CAUSE_ERR] &&
        status_q == STAT_NOACK ##1 !irq_n)
        else $error("unknown command not flagged");
    queue_depth_a: assert property (fcnt_q <= FIFO_DEPTH)
        else $error("queue overfilled");
    reread_keep_a: assert property (
        bev_rd && cmd_q == CMD_REREAD |=> $stable(rd_q))
        else $error("reread moved pointer");
    stretch_end_a: assert property (bev |-> !scl_oe_n ##2 scl_oe_n)
        else $error("clock not released");
    bus_wake_a: assert property (act_ev && !awake_q |=> awake_q)
        else $error("bus activity did not wake");
    addr_match_a: assert property (
        @(negedge scl_clk) disable iff (!lrst_n)
        phase_q == PH_ADDR && bit_q == 4'd7 && !start &&
        shift_q[7:1] != SLAVE_ADDR |=> !ack_q)
        else $error("foreign address acknowledged");

    cover property (bad_cmd);
    cover property (key_valid && fcnt_q == FIFO_DEPTH);
    cover property (act_ev && !awake_q);
    cover property (bev_rd && cmd_q == CMD_REREAD && peek_q != 4'd0);
endmodule

/* dv/bus_host.sv */
/*
 * Behavioural host master for the two-wire command bus.
 * Assumes pull-ups: the bench ANDs scl_h/sda_h with the device pulls.
 */
`timescale 1ns/1ps
module bus_host
(
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_h,
    output logic      sda_h
);
    // ==================================================
    // Bit level, 30 ns link period
    initial
    begin
        scl_h = 1'b1;
        sda_h = 1'b1;
    end
    // Release clock, then wait out a stretch (bounded)
    task automatic rise;
        int n = 0;
        scl_h = 1'b1;
        while (scl !== 1'b1 && n < 300)
        begin
            #5 n++;
        end
    endtask
    // Data moves 5 ns into low so no edge looks like a start
    task automatic bit_io(input logic d, output logic r);
        #5 sda_h = d;
        #10 rise();
        #15 r = sda;
        scl_h = 1'b0;
    endtask
    // Start or repeated start, sda high at the rise
    task automatic start;
        scl_h = 1'b0;
        #5 sda_h = 1'b1;
        #10 rise();
        #8 sda_h = 1'b0;
        #7 scl_h = 1'b0;
    endtask
    task automatic stop;
        scl_h = 1'b0;
        #5 sda_h = 1'b0;
        #10 rise();
        #8 sda_h = 1'b1;
    endtask
    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // Ack every byte but the last, which gets a NACK
    task automatic recv(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, b[i]);
        bit_io(last, r);
    endtask
    // Idle clocks with data high, clock left standing high
    task automatic pulse(input int n);
        logic r;
        repeat (n) bit_io(1'b1, r);
        #5 scl_h = 1'b1;
    endtask
endmodule

/* dv/keypad_host_command_interface_tb.sv */
/*
 * Self-checking bench for the keypad host command interface.
 * Assumes bus_host as master; both wires resolved here with pull-ups.
 */
`timescale 1ns/1ps
module keypad_host_command_interface_tb;
    import kp_host_pkg::*;
    // ==================================================
    // Clock, wires, design and host
    logic  core_clk = 1'b0;
    logic  rst_n = 1'b0;
    logic  key_valid = 1'b0;
    byte_t key_code = 8'h00;
    logic  key_overflow = 1'b0;
    logic  pin0 = 1'b0;
    logic  pin1 = 1'b0;
    logic  scl_o, scl_oe_n, sda_o, sda_oe_n, scl_h, sda_h;
    logic  irq_n, active_mode;
    byte_t debounce_code;
    int    error_cnt = 0;
    int    samples_checked = 0;
    byte_t rb[16];
    wire   scl = scl_h & (scl_oe_n | scl_o);
    wire   sda = sda_h & (sda_oe_n | sda_o);
    initial
    begin
        forever #50 core_clk = ~core_clk;
    end
    // Short step keeps the default halt timer to 2500 cycles
    kp_host_cmd #(.STEP_CYC(20)) kp_host_cmd_inst
    (
        .core_clk(core_clk), .rst_n(rst_n), .scl_clk(scl),
        .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n(sda_oe_n), .key_valid(key_valid),
        .key_code(key_code), .key_overflow(key_overflow),
        .aux_pin_zero(pin0), .aux_pin_one(pin1), .irq_n(irq_n),
        .active_mode(active_mode), .debounce_code(debounce_code)
    );
    bus_host bus_host_inst
        (.scl(scl), .sda(sda), .scl_h(scl_h), .sda_h(sda_h));
    // ==================================================
    // Helpers
    task automatic check_byte(input byte_t got, input byte_t exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected byte at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected bit at %0t: %b not %b", $time, got, exp);
        end
    endtask
    // Ends 5 ns past an edge so registered outputs have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #5;
    endtask
    // A halted device refuses once, so retry after a stop
    task automatic open_addr(input byte_t a);
        logic ack;
        bus_host_inst.start();
        bus_host_inst.send(a, ack);
        if (ack !== 1'b1)
        begin
            bus_host_inst.stop();
            bus_host_inst.start();
            bus_host_inst.send(a, ack);
        end
        check_bit(ack, 1'b1);
    endtask
    task automatic rd(input byte_t c, input int n);
        logic ack;
        open_addr(8'ha2);
        bus_host_inst.send(c, ack);
        bus_host_inst.start();
        bus_host_inst.send(8'ha3, ack);
        for (int k = 0; k < n; k++)
            bus_host_inst.recv(k == n - 1, rb[k]);
        bus_host_inst.stop();
    endtask
    task automatic wr(input byte_t c, input byte_t d);
        logic ack;
        open_addr(8'ha2);
        bus_host_inst.send(c, ack);
        bus_host_inst.send(d, ack);
        bus_host_inst.stop();
        check_bit(ack, 1'b1);
    endtask
    task automatic key(input byte_t c);
        @(posedge core_clk) #5 key_valid = 1'b1;
        key_code = c;
        @(posedge core_clk) #5 key_valid = 1'b0;
    endtask
    // ==================================================
    // Scenarios
    task automatic t_reset;
        check_bit(irq_n, 1'b1);
        check_byte(debounce_code, 8'h03);
        check_bit(scl_oe_n & sda_oe_n, 1'b1);
    endtask
    task automatic t_addr;
        logic ack;
        bus_host_inst.start();
        bus_host_inst.send(8'ha4, ack);
        bus_host_inst.stop();
        check_bit(ack, 1'b0);
        wr(CMD_DEBOUNCE, 8'h07);
        cyc(3);
        check_byte(debounce_code, 8'h07);
        rd(OFS_DEVICE_STATUS, 1);
        check_byte(rb[0], STAT_ACK);
    endtask
    task automatic t_key;
        key(8'h85);
        cyc(3);
        check_bit(irq_n, 1'b0);
        rd(OFS_INTERRUPT_CAUSE, 1);
        check_byte(rb[0], 8'h01);
        cyc(3);
        check_bit(irq_n, 1'b1);
        rd(CMD_FIFO_READ, 2);
        check_byte(rb[0], 8'h85);
        check_byte(rb[1], EMPTY_CODE);
    endtask
    // Fifteenth event overflows; reread must not pop
    task automatic t_queue;
        for (int i = 0; i < 15; i++)
            key(8'h81 + 8'(i));
        key_overflow = 1'b1;
        cyc(1);
        key_overflow = 1'b0;
        rd(CMD_REREAD, 2);
        check_byte(rb[0], 8'h81);
        check_byte(rb[1], 8'h82);
        rd(CMD_FIFO_READ, 15);
        for (int k = 0; k < 14; k++)
            check_byte(rb[k], 8'h81 + 8'(k));
        check_byte(rb[14], EMPTY_CODE);
        rd(OFS_INTERRUPT_CAUSE, 1);
        check_byte(rb[0], 8'h09);
        rd(OFS_FAULT_CAUSE, 1);
        check_byte(rb[0], 8'h44);
        rd(OFS_FAULT_CAUSE, 1);
        check_byte(rb[0], 8'h00);
    endtask
    task automatic t_bad;
        wr(8'h55, 8'h00);
        cyc(3);
        check_bit(irq_n, 1'b0);
        rd(OFS_INTERRUPT_CAUSE, 1);
        check_byte(rb[0], 8'h08);
        rd(OFS_FAULT_CAUSE, 1);
        check_byte(rb[0], 8'h02);
    endtask
    task automatic t_halt;
        logic ack;
        wr(CMD_ACTIVE, 8'h05);
        cyc(200);
        check_bit(active_mode, 1'b0);
        bus_host_inst.start();
        bus_host_inst.send(8'ha2, ack);
        bus_host_inst.stop();
        check_bit(ack, 1'b0);
        open_addr(8'ha2);
        bus_host_inst.stop();
        cyc(200);
        bus_host_inst.start();
        bus_host_inst.send(8'h01, ack);
        bus_host_inst.stop();
        cyc(4);
        check_bit(active_mode, 1'b1);
    endtask
    // One pin enabled sets both bits; two set only their own
    task automatic t_pins;
        wr(CMD_PIN_IRQ, 8'h01);
        cyc(200);
        pin0 = 1'b1;
        cyc(8);
        check_bit(irq_n | ~active_mode, 1'b0);
        rd(OFS_DEVICE_STATUS, 1);
        check_byte(rb[0], STAT_WAKE);
        rd(OFS_INTERRUPT_CAUSE, 1);
        check_byte(rb[0], 8'h06);
        wr(CMD_PIN_IRQ, 8'h03);
        pin1 = 1'b1;
        cyc(8);
        rd(OFS_INTERRUPT_CAUSE, 1);
        check_byte(rb[0], 8'h04);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ==================================================
    // Main sequence and watchdog
    initial
    begin
        fork
            cyc(10);
            bus_host_inst.pulse(30);
        join
        rst_n = 1'b1;
        bus_host_inst.pulse(4);
        t_reset();
        t_addr();
        t_key();
        t_queue();
        t_bad();
        t_halt();
        t_pins();
        report_and_stop();
    end
    initial
    begin
        #3000000;
        error_cnt++;
        report_and_stop();
    end
endmodule
